// file: verilog/qpi_reset_pkg.sv
/*
  constants shared by the quad-exit / software-reset command logic.
  assumes a 125 MHz system clock and no register bus.
*/
package qpi_reset_pkg;
  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_QUAD_EXIT = 8'hff;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam int OPCODE_BITS = 8;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int RESET_TIME_US = 30;
  localparam int RESET_CYCLES = (RESET_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BUSY_CNT_W = 12;
  // ---------------------------------------------------------------
  // power-on values of volatile settings
  // ---------------------------------------------------------------
  localparam logic RST_WRITE_ENABLE = 1'b0;
  localparam logic RST_SUSPEND = 1'b0;
  localparam logic [2:0] RST_WRAP = 3'h0;
  localparam logic [7:0] RST_READ_PARAM = 8'h00;
  localparam logic [7:0] RST_CONT_MODE = 8'h00;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
endpackage

// file: verilog/opcode_capture.sv
/*
  opcode capture: synchronises the serial pins and assembles one opcode
  per chip-select frame, one or four bits per serial clock rising edge.
  assumes the serial clock is far slower than i_clk (pins are sampled).
*/
`timescale 1ns/10ps
`default_nettype none
module opcode_capture (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_cs_b,
  input wire logic i_sclk,
  input wire logic [3:0] i_io,
  input wire logic i_quad_mode,
  output logic o_op_valid,
  output logic [7:0] o_opcode
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] meta_reg, sync_reg, last_reg;
  logic [5:0] meta_next, sync_next, last_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic valid_reg, valid_next;
  logic [7:0] op_reg, op_next;
  logic sclk_rise, cs_rise, cs_low;

  always_comb begin
    meta_next = {i_cs_b, i_sclk, i_io};
    sync_next = meta_reg;
    last_next = sync_reg;
    sclk_rise = sync_reg[4] & ~last_reg[4];
    cs_rise = sync_reg[5] & ~last_reg[5];
    cs_low = ~sync_reg[5];
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    valid_next = 1'b0;
    op_next = op_reg;
    if (cs_low && sclk_rise) begin
      // saturate past one byte so a long frame is never mistaken for an opcode
      if (cnt_reg <= 4'(qpi_reset_pkg::OPCODE_BITS)) begin
        if (i_quad_mode) begin
          shift_next = {shift_reg[3:0], sync_reg[3:0]};
          cnt_next = cnt_reg + 4'h4;
        end else begin
          shift_next = {shift_reg[6:0], sync_reg[0]};
          cnt_next = cnt_reg + 4'h1;
        end
      end
    end
    if (cs_rise) begin
      valid_next = (cnt_reg == 4'(qpi_reset_pkg::OPCODE_BITS));
      op_next = shift_reg;
      cnt_next = qpi_reset_pkg::BIT_CNT_RST;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_reg <= 6'h30;
      sync_reg <= 6'h30;
      last_reg <= 6'h30;
      cnt_reg <= qpi_reset_pkg::BIT_CNT_RST;
      shift_reg <= 8'h00;
      valid_reg <= 1'b0;
      op_reg <= 8'h00;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      valid_reg <= valid_next;
      op_reg <= op_next;
    end
  end

  assign o_op_valid = valid_reg;
  assign o_opcode = op_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence frame_end_odd;
    cs_rise && cnt_reg != 4'h8;
  endsequence
  chk_partial_byte: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    frame_end_odd |=> !o_op_valid) else $error("opcode taken from a partial byte");
  chk_valid_needs_cs: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_op_valid |-> $past(cs_rise)) else $error("opcode without chip select rise");
endmodule
`default_nettype wire

// file: verilog/qpi_exit_and_soft_reset.sv
/*
  quad-exit and two-step software reset command logic of a serial flash.
  assumes other command logic drives the setting load strobes; the
  write-in-progress state is neither reported nor acted on here.
*/
`timescale 1ns/10ps
`default_nettype none
module qpi_exit_and_soft_reset (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_cs_b,
  input wire logic i_sclk,
  input wire logic [3:0] i_io,
  input wire logic i_quad_enter,
  input wire logic i_write_enable_set,
  input wire logic i_write_enable_clr,
  input wire logic i_suspend_set,
  input wire logic i_suspend_clr,
  input wire logic i_wrap_load,
  input wire logic [2:0] i_wrap_data,
  input wire logic i_read_param_load,
  input wire logic [7:0] i_read_param_data,
  input wire logic i_cont_mode_load,
  input wire logic [7:0] i_cont_mode_data,
  output logic o_quad_mode,
  output logic o_reset_armed,
  output logic o_reset_busy,
  output logic o_abort,
  output logic o_write_enable_latch,
  output logic o_suspended,
  output logic [2:0] o_wrap_setting_bits,
  output logic [7:0] o_read_parameter_bits,
  output logic [7:0] o_continuous_read_mode_bits
);
  typedef enum logic [1:0] {RST_IDLE, RST_ARMED, RST_BUSY} rst_state_type;

  logic op_valid;
  logic [7:0] opcode;
  rst_state_type state_reg, state_next;
  logic [qpi_reset_pkg::BUSY_CNT_W-1:0] busy_cnt_reg, busy_cnt_next;
  logic quad_reg, quad_next;
  logic armed_reg, armed_next;
  logic busy_reg, busy_next;
  logic abort_reg, abort_next;
  logic wr_en_reg, wr_en_next;
  logic susp_reg, susp_next;
  logic [2:0] wrap_reg, wrap_next;
  logic [7:0] rparam_reg, rparam_next;
  logic [7:0] cmode_reg, cmode_next;
  logic accept, live;

  opcode_capture u_capture (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_cs_b(i_cs_b),
    .i_sclk(i_sclk),
    .i_io(i_io),
    .i_quad_mode(quad_reg),
    .o_op_valid(op_valid),
    .o_opcode(opcode)
  );

  // ---------------------------------------------------------------
  // reset sequencer and mode
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    busy_cnt_next = busy_cnt_reg;
    quad_next = quad_reg;
    accept = 1'b0;
    live = (state_reg != RST_BUSY);
    case (state_reg)
      RST_IDLE: begin
        if (op_valid && opcode == qpi_reset_pkg::OP_RESET_ENABLE) begin
          state_next = RST_ARMED;
        end
      end
      RST_ARMED: begin
        if (op_valid) begin
          if (opcode == qpi_reset_pkg::OP_RESET) begin
            accept = 1'b1;
            state_next = RST_BUSY;
            busy_cnt_next = qpi_reset_pkg::BUSY_CNT_W'(qpi_reset_pkg::RESET_CYCLES - 1);
          end else if (opcode != qpi_reset_pkg::OP_RESET_ENABLE) begin
            state_next = RST_IDLE;
          end
        end
      end
      RST_BUSY: begin
        // everything arriving now is dropped; host must wait out the window
        if (busy_cnt_reg == '0) begin
          state_next = RST_IDLE;
        end else begin
          busy_cnt_next = busy_cnt_reg - 1'b1;
        end
      end
      default: begin
        state_next = RST_IDLE;
      end
    endcase
    if (accept) begin
      quad_next = 1'b0;
    end else if (live && quad_reg && op_valid && opcode == qpi_reset_pkg::OP_QUAD_EXIT) begin
      quad_next = 1'b0;
    end else if (live && i_quad_enter) begin
      quad_next = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // volatile settings
  // ---------------------------------------------------------------
  // quad exit never touches these, so they survive the mode change
  always_comb begin
    wr_en_next = wr_en_reg;
    susp_next = susp_reg;
    wrap_next = wrap_reg;
    rparam_next = rparam_reg;
    cmode_next = cmode_reg;
    if (accept) begin
      wr_en_next = qpi_reset_pkg::RST_WRITE_ENABLE;
      susp_next = qpi_reset_pkg::RST_SUSPEND;
      wrap_next = qpi_reset_pkg::RST_WRAP;
      rparam_next = qpi_reset_pkg::RST_READ_PARAM;
      cmode_next = qpi_reset_pkg::RST_CONT_MODE;
    end else if (live) begin
      // set wins over a clear in the same cycle
      if (i_write_enable_set) begin
        wr_en_next = 1'b1;
      end else if (i_write_enable_clr) begin
        wr_en_next = 1'b0;
      end
      if (i_suspend_set) begin
        susp_next = 1'b1;
      end else if (i_suspend_clr) begin
        susp_next = 1'b0;
      end
      if (i_wrap_load) begin
        wrap_next = i_wrap_data;
      end
      if (i_read_param_load) begin
        rparam_next = i_read_param_data;
      end
      if (i_cont_mode_load) begin
        cmode_next = i_cont_mode_data;
      end
    end
    armed_next = (state_next == RST_ARMED);
    busy_next = (state_next == RST_BUSY);
    abort_next = accept;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= RST_IDLE;
      busy_cnt_reg <= '0;
      quad_reg <= 1'b0;
      armed_reg <= 1'b0;
      busy_reg <= 1'b0;
      abort_reg <= 1'b0;
      wr_en_reg <= qpi_reset_pkg::RST_WRITE_ENABLE;
      susp_reg <= qpi_reset_pkg::RST_SUSPEND;
      wrap_reg <= qpi_reset_pkg::RST_WRAP;
      rparam_reg <= qpi_reset_pkg::RST_READ_PARAM;
      cmode_reg <= qpi_reset_pkg::RST_CONT_MODE;
    end else begin
      state_reg <= state_next;
      busy_cnt_reg <= busy_cnt_next;
      quad_reg <= quad_next;
      armed_reg <= armed_next;
      busy_reg <= busy_next;
      abort_reg <= abort_next;
      wr_en_reg <= wr_en_next;
      susp_reg <= susp_next;
      wrap_reg <= wrap_next;
      rparam_reg <= rparam_next;
      cmode_reg <= cmode_next;
    end
  end

  assign o_quad_mode = quad_reg;
  assign o_reset_armed = armed_reg;
  assign o_reset_busy = busy_reg;
  assign o_abort = abort_reg;
  assign o_write_enable_latch = wr_en_reg;
  assign o_suspended = susp_reg;
  assign o_wrap_setting_bits = wrap_reg;
  assign o_read_parameter_bits = rparam_reg;
  assign o_continuous_read_mode_bits = cmode_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [qpi_reset_pkg::BUSY_CNT_W:0] busy_run_reg;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_run_reg <= '0;
    end else if (busy_reg) begin
      busy_run_reg <= busy_run_reg + 1'b1;
    end else begin
      busy_run_reg <= '0;
    end
  end

  sequence exit_cmd;
    op_valid && opcode == qpi_reset_pkg::OP_QUAD_EXIT && quad_reg && !busy_reg;
  endsequence
  sequence no_loads;
    !i_write_enable_set && !i_write_enable_clr && !i_suspend_set && !i_suspend_clr
      && !i_wrap_load;
  endsequence
  sequence armed_then_reset;
    state_reg == RST_ARMED ##0 op_valid && opcode == qpi_reset_pkg::OP_RESET;
  endsequence

  chk_quad_exit_back: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    exit_cmd |=> !o_quad_mode) else $error("quad exit did not leave quad mode");
  chk_exit_keeps_state: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (exit_cmd and no_loads) |=> $stable(o_write_enable_latch) && $stable(o_suspended)
      && $stable(o_wrap_setting_bits)) else $error("quad exit changed settings");
  chk_reset_clears: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    armed_then_reset |=> o_abort && !o_write_enable_latch && !o_quad_mode
      && o_wrap_setting_bits == qpi_reset_pkg::RST_WRAP && o_read_parameter_bits == 8'h00
      && o_continuous_read_mode_bits == 8'h00 ##1 !o_abort)
    else $error("reset did not restore defaults");
  chk_enable_any_mode: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    state_reg == RST_IDLE && op_valid && opcode == qpi_reset_pkg::OP_RESET_ENABLE
      |=> o_reset_armed) else $error("reset enable not accepted");
  chk_reset_needs_arm: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    op_valid && opcode == qpi_reset_pkg::OP_RESET && state_reg == RST_IDLE
      |=> !o_abort && !o_reset_busy) else $error("reset without reset enable");
  chk_other_disarms: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    state_reg == RST_ARMED && op_valid && opcode != qpi_reset_pkg::OP_RESET
      && opcode != qpi_reset_pkg::OP_RESET_ENABLE |=> !o_reset_armed ##1 !o_abort)
    else $error("reset enable survived another command");
  chk_busy_length: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $fell(o_reset_busy) |-> $past(busy_run_reg) ==
      (qpi_reset_pkg::BUSY_CNT_W+1)'(qpi_reset_pkg::RESET_CYCLES - 1))
    else $error("reset busy window has wrong length");
  chk_busy_ignores: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    busy_reg && state_reg == RST_BUSY |=> !o_quad_mode && !o_reset_armed && !o_abort)
    else $error("command acted on during reset");
  chk_power_up_idle: assert property (@(posedge i_clk)
    !i_rst_b |=> !o_reset_armed || !i_rst_b) else $error("armed after power-up");
endmodule
`default_nettype wire

// file: sim/host_model.sv
/*
  host model: one opcode per chip-select frame, spi or quad.
  assumes the device oversamples the pins with a fast clock.
*/
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic i_clk,
  output logic o_cs_b,
  output logic o_sclk,
  output logic [3:0] o_io
);
  initial begin
    o_cs_b = 1'b1;
    o_sclk = 1'b0;
    o_io = 4'h0;
  end
  // ------------------------------
  // framing
  // ------------------------------
  // sclk rests low outside frames; released data shows the inverse,
  // so a stale bit can never pass for a good one
  task automatic send(input logic [7:0] op, input logic quad, input int edges);
    int i;
    logic [3:0] d;
    repeat (4) @(negedge i_clk);
    o_cs_b = 1'b0;
    for (i = 0; i < edges; i++) begin
      d = quad ? ((i == 0) ? op[7:4] : op[3:0]) : {3'h0, op[7 - i]};
      o_io = d;
      repeat (4) @(negedge i_clk);
      o_sclk = 1'b1;
      repeat (4) @(negedge i_clk);
      o_sclk = 1'b0;
      o_io = ~d;
    end
    repeat (4) @(negedge i_clk);
    o_cs_b = 1'b1;
    repeat (4) @(negedge i_clk);
  endtask
endmodule
`default_nettype wire

// file: sim/qpi_exit_and_soft_reset_tb.sv
/*
  self-checking bench for the quad-exit and software reset logic.
  assumes the host model drives the serial pins.
*/
`timescale 1ns/10ps
`default_nettype none
module qpi_exit_and_soft_reset_tb;
  logic i_clk, i_rst_b, cs_b, sclk, q_en, we_set, sus_set, wrap_ld, rp_ld, cm_ld;
  logic we_clr, sus_clr;
  logic [3:0] io;
  logic quad, armed, busy, abort, wr_en, sus;
  logic [2:0] wrap;
  logic [7:0] rp, cm;
  int err_count, cmp_count, abort_cnt, busy_len;
  host_model host (.i_clk(i_clk), .o_cs_b(cs_b), .o_sclk(sclk), .o_io(io));
  qpi_exit_and_soft_reset dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cs_b(cs_b),
    .i_sclk(sclk), .i_io(io), .i_quad_enter(q_en), .i_write_enable_set(we_set),
    .i_write_enable_clr(we_clr), .i_suspend_set(sus_set), .i_suspend_clr(sus_clr),
    .i_wrap_load(wrap_ld), .i_wrap_data(3'h5), .i_read_param_load(rp_ld),
    .i_read_param_data(8'ha5), .i_cont_mode_load(cm_ld), .i_cont_mode_data(8'h3c),
    .o_quad_mode(quad), .o_reset_armed(armed), .o_reset_busy(busy), .o_abort(abort),
    .o_write_enable_latch(wr_en), .o_suspended(sus), .o_wrap_setting_bits(wrap),
    .o_read_parameter_bits(rp), .o_continuous_read_mode_bits(cm));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // abort pulse starts the busy window, so its length is counted from there
  always @(posedge i_clk) begin
    if (abort === 1'b1) begin
      abort_cnt++;
      busy_len = 1;
    end else if (busy === 1'b1) begin
      busy_len++;
    end
  end
  // ------------------------------
  // helpers
  // ------------------------------
  task automatic report_and_stop();
    $display("counts: compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge i_clk);
    s = 1'b1;
    @(negedge i_clk);
    s = 1'b0;
  endtask
  task automatic load_all();
    @(negedge i_clk);
    {we_set, sus_set, wrap_ld, rp_ld, cm_ld} = 5'h1f;
    @(negedge i_clk);
    {we_set, sus_set, wrap_ld, rp_ld, cm_ld} = 5'h00;
    @(negedge i_clk);
  endtask
  task automatic settle();
    repeat (6) @(negedge i_clk);
  endtask
  task automatic chk_settings(input logic on);
    chk(wr_en, on);
    chk(sus, on);
    chk(wrap, on ? 3'h5 : 3'h0);
    chk(rp, on ? 8'ha5 : 8'h00);
    chk(cm, on ? 8'h3c : 8'h00);
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 5000 && busy !== 1'b0; n++) @(negedge i_clk);
    if (busy !== 1'b0) begin
      err_count++;
      report_and_stop();
    end
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_reset();
    int a0;
    // poll busy before the reset sequence, never reset mid-operation
    wait_idle();
    load_all();
    host.send(8'h66, 1'b0, 8);
    settle();
    chk(armed, 1'b1);
    a0 = abort_cnt;
    host.send(8'h99, 1'b0, 8);
    settle();
    chk(busy, 1'b1);
    chk(abort_cnt - a0, 1);
    chk(armed, 1'b0);
    chk_settings(1'b0);
    load_all();
    host.send(8'h66, 1'b0, 8);
    settle();
    chk(armed, 1'b0);
    chk(wr_en, 1'b0);
    wait_idle();
    chk(busy_len, 16'h0ea6);
    $display("test reset done");
  endtask
  task automatic t_disarm();
    host.send(8'h66, 1'b0, 8);
    host.send(8'hff, 1'b0, 8);
    settle();
    chk(armed, 1'b0);
    host.send(8'h99, 1'b0, 8);
    settle();
    chk(busy, 1'b0);
    host.send(8'h66, 1'b0, 7);
    settle();
    chk(armed, 1'b0);
    host.send(8'h66, 1'b0, 8);
    host.send(8'h66, 1'b0, 8);
    settle();
    chk(armed, 1'b1);
    host.send(8'hff, 1'b0, 8);
    settle();
    chk(armed, 1'b0);
    $display("test disarm done");
  endtask
  task automatic t_clears();
    @(negedge i_clk);
    {we_set, sus_set, we_clr, sus_clr} = 4'hf;
    @(negedge i_clk);
    {we_set, sus_set, we_clr, sus_clr} = 4'h0;
    @(negedge i_clk);
    chk(wr_en, 1'b1);
    chk(sus, 1'b1);
    pulse(we_clr);
    pulse(sus_clr);
    @(negedge i_clk);
    chk(wr_en, 1'b0);
    chk(sus, 1'b0);
    pulse(q_en);
    host.send(8'hff, 1'b1, 2);
    settle();
    chk(quad, 1'b0);
    chk(wr_en, 1'b0);
    chk(sus, 1'b0);
    $display("test clears done");
  endtask
  task automatic t_power();
    pulse(q_en);
    host.send(8'h66, 1'b1, 2);
    settle();
    chk(armed, 1'b1);
    @(negedge i_clk);
    i_rst_b = 1'b0;
    repeat (2) @(negedge i_clk);
    chk(armed, 1'b0);
    chk(quad, 1'b0);
    i_rst_b = 1'b1;
    repeat (3) @(negedge i_clk);
    host.send(8'h99, 1'b0, 8);
    settle();
    chk(busy, 1'b0);
    chk(armed, 1'b0);
    $display("test power done");
  endtask
  task automatic t_quad();
    pulse(q_en);
    load_all();
    chk(quad, 1'b1);
    host.send(8'hff, 1'b1, 2);
    settle();
    chk(quad, 1'b0);
    chk_settings(1'b1);
    pulse(q_en);
    host.send(8'h66, 1'b1, 2);
    host.send(8'h99, 1'b1, 2);
    settle();
    chk(busy, 1'b1);
    chk(quad, 1'b0);
    chk_settings(1'b0);
    wait_idle();
    $display("test quad done");
  endtask
  initial begin
    {i_rst_b, q_en, we_set, sus_set, wrap_ld, rp_ld, cm_ld, we_clr, sus_clr} = 9'h000;
    err_count = 0;
    cmp_count = 0;
    abort_cnt = 0;
    busy_len = 0;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk(armed, 1'b0);
    i_rst_b = 1'b1;
    repeat (3) @(negedge i_clk);
    t_reset();
    t_clears();
    t_disarm();
    t_quad();
    t_power();
    report_and_stop();
  end
endmodule
`default_nettype wire
